// file: design/ccs_core_cache_clock.sv
// core and cache clock setup: strap capture, mode select, cache clock divider,
// feedback phase measurement and wishbone registers.
// assumes straps and feedback input are asynchronous pins; wishbone on clk_sys.
//
// Overview of operation
// - bypass: pll off, bus clock, 1:1 ratio
// - pll-off mode: no internal clocking at all
// - cache clock divides core clock, 1..4 halves
// - divisor comes from software control field
// - feedback clock out, returned, phase measured
// - strap sets 2x..9x multiplier, vco twice core
// - 0011 selects bypass, 1111 selects pll off
`default_nettype none
module ccs_core_cache_clock #(
  parameter int unsigned DLL_MAX_PHASE = 16
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // board straps and feedback pin
  input wire logic [3:0] core_ratio_strap,
  input wire logic cache_feedback_clock_in,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock control outputs
  output logic pll_enable,
  output logic pll_bypass,
  output logic core_clock_enable,
  output logic bus_ratio_one,
  output logic [4:0] core_mult_x2,
  output logic [5:0] vco_mult_x2,
  output logic cache_clock_tick,
  output logic cache_feedback_clock_out,
  output logic slow_cache_clock_select,
  output logic dll_locked
);
  // phase counter is eight bits wide
  if (DLL_MAX_PHASE < 1 || DLL_MAX_PHASE > 255) begin : g_bad_phase
    $error("DLL_MAX_PHASE out of range");
  end

  typedef struct packed {
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic fb_s1;
    logic fb_s2;
    logic fb_prev;
    logic [1:0] settle;
    logic captured;
    logic [3:0] strap;
    ccs_pkg::ccs_mode_t mode;
    logic pll_on;
    logic bypass_on;
    logic core_on;
    logic [4:0] mult_x2;
    logic [2:0] div_code;
    logic slow;
    logic cache_en;
    logic [3:0] acc;
    logic tick;
    logic measuring;
    logic [7:0] phase_cnt;
    logic [7:0] phase;
    logic locked;
    logic ack;
    logic [31:0] rdata;
  } ccs_state_t;

  ccs_state_t s_reg;
  ccs_state_t s_next;

  // bus-to-core multiplier times two; zero for non-pll codes
  function automatic logic [4:0] ccs_mult_x2_of(input logic [3:0] code);
    unique case (code)
      4'h4: ccs_mult_x2_of = 5'h04;
      4'h6: ccs_mult_x2_of = 5'h05;
      4'h8: ccs_mult_x2_of = 5'h06;
      4'he: ccs_mult_x2_of = 5'h07;
      4'ha: ccs_mult_x2_of = 5'h08;
      4'h7: ccs_mult_x2_of = 5'h09;
      4'hb: ccs_mult_x2_of = 5'h0a;
      4'h9: ccs_mult_x2_of = 5'h0b;
      4'hd: ccs_mult_x2_of = 5'h0c;
      4'h5: ccs_mult_x2_of = 5'h0d;
      4'h2: ccs_mult_x2_of = 5'h0e;
      4'h1: ccs_mult_x2_of = 5'h0f;
      4'hc: ccs_mult_x2_of = 5'h10;
      4'h0: ccs_mult_x2_of = 5'h12;
      default: ccs_mult_x2_of = 5'h00;
    endcase
  endfunction

  logic req;
  logic wr_ctrl;
  logic [4:0] div_halves;
  logic [3:0] acc_sum;
  logic core_tick;
  logic fb_rise;

  always_comb begin
    s_next = s_reg;
    req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ccs_pkg::OFF_CTRL);
    div_halves = {2'h0, s_reg.div_code} + 5'h02;
    acc_sum = s_reg.acc + 4'h2;
    core_tick = (s_reg.mode != ccs_pkg::CCS_MODE_OFF) && s_reg.captured;
    fb_rise = s_reg.fb_s2 && !s_reg.fb_prev;

    // pin synchronisers
    s_next.strap_s1 = core_ratio_strap;
    s_next.strap_s2 = s_reg.strap_s1;
    s_next.fb_s1 = cache_feedback_clock_in;
    s_next.fb_s2 = s_reg.fb_s1;
    s_next.fb_prev = s_reg.fb_s2;

    // straps caught once after reset, then held until the next reset
    if (!s_reg.captured) begin
      if (s_reg.settle == ccs_pkg::STRAP_SETTLE) begin
        s_next.captured = 1'b1;
        s_next.strap = s_reg.strap_s2;
        s_next.mult_x2 = ccs_mult_x2_of(s_reg.strap_s2);
        if (s_reg.strap_s2 == ccs_pkg::STRAP_BYPASS) begin
          s_next.mode = ccs_pkg::CCS_MODE_BYPASS;
        end else if (ccs_mult_x2_of(s_reg.strap_s2) != 5'h00) begin
          s_next.mode = ccs_pkg::CCS_MODE_PLL;
        end else begin
          s_next.mode = ccs_pkg::CCS_MODE_OFF; // only the 1111 off code reaches this branch
        end
      end else begin
        s_next.settle = s_reg.settle + 2'h1;
      end
    end

    // mode decode registered so every mode output is a flop
    s_next.pll_on = (s_next.mode == ccs_pkg::CCS_MODE_PLL);
    s_next.bypass_on = (s_next.mode == ccs_pkg::CCS_MODE_BYPASS);
    s_next.core_on = (s_next.mode != ccs_pkg::CCS_MODE_OFF);

    // fractional divider: one tick per div_halves/2 core cycles
    s_next.tick = 1'b0;
    if (core_tick && s_reg.cache_en) begin
      if ({1'b0, acc_sum} >= div_halves) begin
        s_next.acc = acc_sum - div_halves[3:0];
        s_next.tick = 1'b1;
      end else begin
        s_next.acc = acc_sum;
      end
    end

    // feedback round trip measurement; a return meeting the next tick still counts
    if (s_reg.measuring) begin
      if (fb_rise) begin
        s_next.measuring = 1'b0;
        s_next.phase = s_reg.phase_cnt;
      end else if (s_reg.phase_cnt != 8'hff) begin
        s_next.phase_cnt = s_reg.phase_cnt + 8'h01;
      end
    end
    if (s_reg.tick) begin
      s_next.measuring = 1'b1;
      s_next.phase_cnt = 8'h00;
    end

    // register writes
    if (wr_ctrl) begin
      if (wb_dat_i[ccs_pkg::DIV_LSB +: ccs_pkg::DIV_W] <= ccs_pkg::DIV_MAX_CODE) begin
        s_next.div_code = wb_dat_i[ccs_pkg::DIV_LSB +: ccs_pkg::DIV_W];
        s_next.acc = 4'h0;
      end
      s_next.slow = wb_dat_i[ccs_pkg::SLOW_BIT];
      s_next.cache_en = wb_dat_i[ccs_pkg::CEN_BIT];
      s_next.locked = 1'b0;
    end
    // lock set wins over a clear in the same cycle
    if (s_reg.measuring && fb_rise && (s_reg.phase_cnt <= 8'(DLL_MAX_PHASE))) begin
      s_next.locked = 1'b1;
    end

    // wishbone answer one cycle after the request, dropped next cycle
    s_next.ack = req;
    s_next.rdata = 32'h0;
    if (req && !wb_we_i) begin
      if (wb_adr_i == ccs_pkg::OFF_CTRL) begin
        s_next.rdata[ccs_pkg::DIV_LSB +: ccs_pkg::DIV_W] = s_reg.div_code;
        s_next.rdata[ccs_pkg::SLOW_BIT] = s_reg.slow;
        s_next.rdata[ccs_pkg::CEN_BIT] = s_reg.cache_en;
      end else if (wb_adr_i == ccs_pkg::OFF_STATUS) begin
        s_next.rdata[ccs_pkg::ST_STRAP_LSB +: 4] = s_reg.strap;
        s_next.rdata[ccs_pkg::ST_MODE_LSB +: 2] = s_reg.mode;
        s_next.rdata[ccs_pkg::ST_MULT_LSB +: 5] = s_reg.mult_x2;
        s_next.rdata[ccs_pkg::ST_RSVD_BIT] = s_reg.captured
          && (s_reg.mode == ccs_pkg::CCS_MODE_OFF) && (s_reg.strap != ccs_pkg::STRAP_OFF);
        s_next.rdata[ccs_pkg::ST_LOCK_BIT] = s_reg.locked;
        s_next.rdata[ccs_pkg::ST_PHASE_LSB +: ccs_pkg::PHASE_W] = s_reg.phase;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.mode <= ccs_pkg::CCS_MODE_OFF;
      s_reg.div_code <= ccs_pkg::DIV_RESET;
      s_reg.cache_en <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign pll_enable = s_reg.pll_on;
  assign pll_bypass = s_reg.bypass_on;
  assign core_clock_enable = s_reg.core_on;
  assign bus_ratio_one = s_reg.bypass_on;
  assign core_mult_x2 = s_reg.mult_x2;
  assign vco_mult_x2 = {s_reg.mult_x2, 1'b0};
  assign cache_clock_tick = s_reg.tick;
  assign cache_feedback_clock_out = s_reg.tick;
  assign slow_cache_clock_select = s_reg.slow;
  assign dll_locked = s_reg.locked;
endmodule
`default_nettype wire

// file: design/ccs_pkg.sv
// constants for the core and cache clock setup block
// assumes one 25 MHz system clock and a classic wishbone register port
`default_nettype none
package ccs_pkg;
  localparam int unsigned CLK_MHZ = 25;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  // control register fields
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int SLOW_BIT = 3;
  localparam int CEN_BIT = 4;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] DIV_MAX_CODE = 3'h6;
  // status register fields
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MULT_LSB = 6;
  localparam int ST_RSVD_BIT = 11;
  localparam int ST_LOCK_BIT = 12;
  localparam int ST_PHASE_LSB = 16;
  localparam int PHASE_W = 8;
  // strap encodings with special meaning
  localparam logic [3:0] STRAP_BYPASS = 4'h3;
  localparam logic [3:0] STRAP_OFF = 4'hf;
  // cycles from reset release until synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  typedef enum logic [1:0] {
    CCS_MODE_OFF = 2'b00,
    CCS_MODE_PLL = 2'b01,
    CCS_MODE_BYPASS = 2'b10
  } ccs_mode_t;
endpackage
`default_nettype wire

// file: test/ccs_board_model.sv
// board model: feedback clock trace out and back
// assumes clk_sys times the board
`default_nettype none
module ccs_board_model #(
  parameter int DLY = 2
) (
  input wire logic clk_sys,
  input wire logic fb_out,
  output var logic fb_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DLY-1:0] line = '0;
  // returned pulse after the trace delay
  always_ff @(posedge clk_sys) line <= {line[DLY-2:0], fb_out};
  assign fb_in = line[DLY-1];
endmodule
`default_nettype wire

// file: test/ccs_asserts.sv
// checker for mode and cache clock outputs
// assumes binding to the block's top module
`default_nettype none
module ccs_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // outputs
  input wire logic wb_ack_o,
  input wire logic pll_enable,
  input wire logic pll_bypass,
  input wire logic core_clock_enable,
  input wire logic bus_ratio_one,
  input wire logic [4:0] core_mult_x2,
  input wire logic [5:0] vco_mult_x2,
  input wire logic cache_clock_tick,
  input wire logic cache_feedback_clock_out,
  input wire logic dll_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_bypass_ratio: assert property (pll_bypass |-> bus_ratio_one && !pll_enable)
    else $error("bypass without 1:1");
  a_off_no_clock: assert property (!core_clock_enable |-> !cache_clock_tick && !pll_bypass)
    else $error("clock in off mode");
  a_bypass_mult: assert property (pll_bypass |-> core_mult_x2 == 5'h0 && core_clock_enable)
    else $error("bypass decode");
  a_vco_twice: assert property (vco_mult_x2 == {core_mult_x2, 1'b0})
    else $error("vco not twice core");
  a_mult_range: assert property (pll_enable |-> core_mult_x2 inside {[5'h4:5'h12]})
    else $error("multiplier out of range");
  a_fb_tick: assert property (cache_feedback_clock_out == cache_clock_tick)
    else $error("feedback out apart from tick");
  a_tick_clocked: assert property (cache_clock_tick |-> pll_enable || pll_bypass)
    else $error("tick without core clock");
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  cover property (pll_bypass);
  cover property (dll_locked);
  cover property (cache_clock_tick ##1 cache_clock_tick);
endmodule
bind ccs_core_cache_clock ccs_asserts ccs_asserts_inst (.*);
`default_nettype wire

// file: test/tb_ccs_core_cache_clock.sv
// bench for core and cache clock setup
// assumes design, board model and checker compiled first
`default_nettype none
module tb_ccs_core_cache_clock;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, cyc = 0, we = 0, ce = 1, fbi;
  logic [3:0] strap = 4'h4, adr = 4'h0;
  logic [31:0] wdat = '0, rdat, q;
  logic ack, pe, pb, cce, r1, tick, fbo, slow, lock;
  logic [4:0] m2;
  logic [5:0] v2;
  int err_total = 0, checked = 0;
  initial forever #20 clk_sys = ~clk_sys;
  ccs_core_cache_clock ccs_core_cache_clock_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .core_ratio_strap(strap), .cache_feedback_clock_in(fbi), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pll_enable(pe), .pll_bypass(pb), .core_clock_enable(cce),
    .bus_ratio_one(r1), .core_mult_x2(m2), .vco_mult_x2(v2), .cache_clock_tick(tick),
    .cache_feedback_clock_out(fbo), .slow_cache_clock_select(slow), .dll_locked(lock));
  ccs_board_model ccs_board_model_inst (.clk_sys(clk_sys), .fb_out(fbo), .fb_in(fbi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    // ack stands one cycle only
    @(posedge clk_sys);
    chk(ack, 0);
  endtask
  task automatic boot(input logic [3:0] s);
    @(posedge clk_sys);
    rstn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_modes();
    logic [3:0] s [4] = '{4'h4, 4'h0, 4'h3, 4'hf};
    logic [4:0] m [4] = '{5'h4, 5'h12, 5'h0, 5'h0};
    for (int i = 0; i < 4; i++) begin
      boot(s[i]);
      chk({pe, pb, r1, cce, m2, v2}, {i < 2, i == 2, i == 2, i != 3, m[i], m[i], 1'b0});
    end
    $display("modes done");
  endtask
  task automatic t_div();
    logic [2:0] c [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
    logic [31:0] e [5] = '{12, 8, 6, 3, 3};
    logic [31:0] n;
    boot(4'h4);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 4'h0, {27'h0, 1'b1, c[i][0], c[i]});
      n = 0;
      repeat (12) begin
        @(posedge clk_sys);
        #1;
        n += tick;
      end
      chk(n, e[i]);
      chk(slow, c[i][0]);
    end
    $display("divisor done");
  endtask
  task automatic t_dll();
    repeat (30) @(posedge clk_sys);
    #1;
    chk(lock, 1);
    bus(1'b0, 4'h4, 0);
    chk(q[12:0], {1'b1, 1'b0, 5'h4, 2'h1, 4'h4});
    // two trace flops plus two sync flops, count starts at zero
    chk(q[23:16], 8'h03);
    bus(1'b0, 4'h8, 0);
    chk(q, 0);
    $display("feedback done");
  endtask
  task automatic t_freeze();
    logic t0;
    logic [31:0] n;
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    #1;
    t0 = tick;
    n = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      n += (tick !== t0);
    end
    chk(n, 0);
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      n += tick;
    end
    chk(n, 3);
    $display("freeze done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    t_modes();
    t_div();
    t_dll();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
